// ---- pkg/trig_pkg.sv ----
// constants and types shared by the trigger qualify and delay unit
// How it works
// RULE_01: qualify setting applies only to external lines
// RULE_02: rising mode fires on low-to-high after inversion
// RULE_03: falling mode fires on high-to-low transition
// RULE_04: any-edge mode fires on every transition
// RULE_05: level-high mode valid while signal stays high
// RULE_06: level-low mode valid while signal stays low
// RULE_07: edges for timed exposure, levels set width
// RULE_08: overlap off drops frame triggers while frame active
// RULE_09: readout overlap accepts line once exposure ends
// RULE_10: source keeps overlapped exposure past prior readout
// RULE_11: prior-capture overlap latches line trigger anytime
// RULE_12: only frame triggers delayed by programmed count
// RULE_13: up to 128 in flight, extras discarded
// RULE_14: microsecond source advances once per microsecond
// RULE_15: line source counts every line pulse, even rejected
// RULE_16: line trigger rate measured, readable anytime
// RULE_17: reverse counter range kept small and bounded
// RULE_18: reverse travel regained before outputs resume
// RULE_19: reverse counter saturates, never wraps
// RULE_20: motion mode pulses every step, either direction
// RULE_21: forward sense selects which phase leads
package trig_pkg;
	// clock and timebase
	localparam int unsigned CLK_PERIOD_NS  = 5;
	localparam int unsigned TICK_PERIOD_NS = 1000;
	localparam int unsigned US_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned RATE_GATE_S    = 1;
	localparam int unsigned RATE_GATE_CYC  =
		RATE_GATE_S * 1000000000 / CLK_PERIOD_NS;

	// delay slots
	localparam int unsigned SLOT_DEPTH = 128;
	localparam int unsigned SLOT_AW    = 7;
	localparam int unsigned STAMP_W    = 32;
	localparam logic [7:0]  SLOT_FULL  = 8'h80;

	// encoder reverse tracking
	localparam logic [8:0] REV_LIMIT = 9'h100;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_DELAY  = 8'h04;
	localparam logic [7:0] OFS_RATE   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// control register fields
	localparam int unsigned CTRL_W      = 13;
	localparam int unsigned F_QSEL      = 0;
	localparam int unsigned F_WIN       = 3;
	localparam int unsigned F_FOVL      = 5;
	localparam int unsigned F_DSEL      = 6;
	localparam int unsigned F_GMODE     = 7;
	localparam int unsigned F_FSENSE    = 8;
	localparam int unsigned F_INV       = 9;
	localparam int unsigned F_LSRC      = 10;
	localparam int unsigned F_FSRC      = 12;
	localparam logic [12:0] CTRL_RST    = 13'h0000;
	localparam logic [31:0] DELAY_RST   = 32'h0000_0000;

	// status register fields
	localparam int unsigned F_PEND = 0;
	localparam int unsigned F_DROP = 8;
	localparam int unsigned F_REV  = 16;

	// pin indices in the synchroniser
	localparam int unsigned PIN_LINE  = 0;
	localparam int unsigned PIN_FRAME = 1;
	localparam int unsigned PIN_A     = 2;
	localparam int unsigned PIN_B     = 3;

	typedef enum logic [2:0] {
		QUAL_RISE = 3'b000,
		QUAL_FALL = 3'b001,
		QUAL_ANY  = 3'b010,
		QUAL_HIGH = 3'b011,
		QUAL_LOW  = 3'b100
	} trig_qualify_select_t;

	typedef enum logic [1:0] {
		WIN_OFF     = 2'b00,
		WIN_READOUT = 2'b01,
		WIN_PRIOR   = 2'b10
	} accept_window_select_t;

	localparam logic [1:0] LSRC_PIN = 2'h0;
	localparam logic [1:0] LSRC_INT = 2'h1;
	localparam logic [1:0] LSRC_ENC = 2'h2;
endpackage

// ---- core/slot_mem.sv ----
// stamp memory for the frame trigger delay slots
`timescale 1ns/1ps
module slot_mem (
	input  wire logic                         clk_sys_i, // system clock
	input  wire logic                         sys_rst_i, // async reset
	input  wire logic                         we_i,      // write strobe
	input  wire logic [trig_pkg::SLOT_AW-1:0] waddr_i,   // write slot
	input  wire logic [trig_pkg::STAMP_W-1:0] wdata_i,   // due stamp
	input  wire logic [trig_pkg::SLOT_AW-1:0] raddr_i,   // read slot
	output logic      [trig_pkg::STAMP_W-1:0] rdata_o    // registered
);
	logic [trig_pkg::STAMP_W-1:0] mem [trig_pkg::SLOT_DEPTH];

	// array kept without reset so it maps onto block ram
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// read is one cycle late; the owner waits for it to settle
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// ---- core/trig_unit.sv ----
// trigger qualify, accept, delay, rate and encoder gating unit
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module trig_unit #(
	parameter int unsigned GATE_CYC = trig_pkg::RATE_GATE_CYC
) (
	input  wire logic        clk_sys_i,        // system clock
	input  wire logic        sys_rst_i,        // async reset
	input  wire logic        psel_i,           // apb select
	input  wire logic        penable_i,        // apb access phase
	input  wire logic        pwrite_i,         // apb direction
	input  wire logic [7:0]  paddr_i,          // apb byte address
	input  wire logic [31:0] pwdata_i,         // apb write data
	output logic             pready_o,         // apb ready
	output logic      [31:0] prdata_o,         // apb read data
	output logic             pslverr_o,        // apb error
	input  wire logic        line_pin_i,       // external line pin
	input  wire logic        frame_pin_i,      // external frame pin
	input  wire logic        enc_a_i,          // encoder phase a pin
	input  wire logic        enc_b_i,          // encoder phase b pin
	input  wire logic        int_line_i,       // internal line pulse
	input  wire logic        int_frame_i,      // internal frame pulse
	input  wire logic        exposure_active_i, // exposure running
	input  wire logic        readout_active_i, // readout running
	input  wire logic        frame_active_i,   // frame running
	output logic             line_trig_o,      // accepted line trig
	output logic             delayed_trigger_out_o, // delayed frame
	output logic             enc_trig_o        // gated encoder step
);
	typedef struct packed {
		// pin synchroniser stages, stable value and last stable value
		logic [3:0]  s1;
		logic [3:0]  s2;
		logic [3:0]  s3;
		logic [3:0]  stab;
		logic [3:0]  prev;
		// software-visible settings
		logic [trig_pkg::CTRL_W-1:0] ctrl;
		logic [31:0] delay;
		// line channel state
		logic        pend;
		logic        lvl;
		logic        line_out;
		logic        enc_out;
		// encoder reverse distance, saturating
		logic [8:0]  rev;
		// delay timebase and slot ring
		logic [7:0]  usdiv;
		logic [31:0] tcount;
		logic [6:0]  wptr;
		logic [6:0]  rptr;
		logic [7:0]  cnt;
		logic [1:0]  stale;
		logic [7:0]  drops;
		// delayed trigger pulse
		logic        fire;
		// rate measurement
		logic [31:0] gate;
		logic [31:0] pcount;
		logic [31:0] rate;
		// registered apb answer
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} state_t;

	state_t        st_ff;
	state_t        nxt_st;
	logic          mem_we;
	logic [6:0]    mem_waddr;
	logic [31:0]   mem_wdata;
	logic [31:0]   mem_rdata;

	// edge or level start for one stable signal
	function automatic logic qual_event(input logic [2:0] m,
			input logic cur, input logic old);
		logic ev;
		ev = 1'b0;
		case (m)
			trig_pkg::QUAL_RISE: ev = cur & ~old;  // [RULE_02]
			trig_pkg::QUAL_FALL: ev = ~cur & old;  // [RULE_03]
			trig_pkg::QUAL_ANY:  ev = cur ^ old;   // [RULE_04]
			// level modes start on the edge into the valid level;
			// holding the level is left to the caller
			trig_pkg::QUAL_HIGH: ev = cur & ~old;
			trig_pkg::QUAL_LOW:  ev = ~cur & old;
			default:             ev = 1'b0;
		endcase
		return ev;
	endfunction

	slot_mem u_slot_mem (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.we_i      (mem_we),
		.waddr_i   (mem_waddr),
		.wdata_i   (mem_wdata),
		.raddr_i   (st_ff.rptr),
		.rdata_o   (mem_rdata)
	);

	// whole next-state computation
	always_comb begin
		logic [2:0]  qsel;
		logic [1:0]  win;
		logic [1:0]  lsrc;
		logic        is_lvl;
		logic        l_cur;
		logic        l_old;
		logic        l_ev;
		logic        l_valid;
		logic        busy;
		logic        f_cur;
		logic        f_old;
		logic        f_ev;
		logic        f_acc;
		logic        tick;
		logic        pop;
		logic        push;
		logic [31:0] diff;
		logic        a_old;
		logic        b_new;
		logic        step;
		logic        fwd;
		logic        acc;
		logic [31:0] rd;
		logic        hit;
		nxt_st  = st_ff;
		qsel    = st_ff.ctrl[trig_pkg::F_QSEL +: 3];
		win     = st_ff.ctrl[trig_pkg::F_WIN +: 2];
		lsrc    = st_ff.ctrl[trig_pkg::F_LSRC +: 2];
		is_lvl  = (qsel == trig_pkg::QUAL_HIGH) ||
			(qsel == trig_pkg::QUAL_LOW);
		l_ev    = 1'b0;
		l_valid = 1'b0;
		f_ev    = 1'b0;
		rd      = 32'h0000_0000;
		hit     = 1'b1;
		// locals start at a known value so no path leaves a latch
		l_cur   = 1'b0;
		l_old   = 1'b0;
		busy    = 1'b0;
		f_cur   = 1'b0;
		f_old   = 1'b0;
		f_acc   = 1'b0;
		tick    = 1'b0;
		pop     = 1'b0;
		push    = 1'b0;
		diff    = 32'h0000_0000;
		a_old   = 1'b0;
		b_new   = 1'b0;
		step    = 1'b0;
		fwd     = 1'b0;
		acc     = 1'b0;

		// three-stage sync; a change counts once stages two and three agree
		nxt_st.s1   = {enc_b_i, enc_a_i, frame_pin_i, line_pin_i};
		nxt_st.s2   = st_ff.s1;
		nxt_st.s3   = st_ff.s2;
		nxt_st.stab = (st_ff.s2 & st_ff.s3) |
			(st_ff.stab & (st_ff.s2 ^ st_ff.s3));
		nxt_st.prev = st_ff.stab;

		// line channel: pin after inversion, internal or encoder step
		l_cur = st_ff.stab[trig_pkg::PIN_LINE] ^ st_ff.ctrl[trig_pkg::F_INV];
		l_old = st_ff.prev[trig_pkg::PIN_LINE] ^ st_ff.ctrl[trig_pkg::F_INV];
		if (lsrc == trig_pkg::LSRC_PIN) begin
			l_ev    = qual_event(qsel, l_cur, l_old);     // [RULE_02]
			l_valid = (qsel == trig_pkg::QUAL_HIGH) ? l_cur // [RULE_05]
				: ~l_cur;                                 // [RULE_06]
		end else if (lsrc == trig_pkg::LSRC_INT) begin
			l_ev = int_line_i;                            // [RULE_01]
		end else if (lsrc == trig_pkg::LSRC_ENC) begin
			l_ev = st_ff.enc_out;                         // [RULE_01]
		end

		// busy window for a new line depends on the overlap choice
		// prior-capture window keeps the full busy span but latches one
		// trigger; further ones in that span are dropped
		case (win)
			trig_pkg::WIN_READOUT: busy = exposure_active_i; // [RULE_09]
			trig_pkg::WIN_PRIOR:   busy = exposure_active_i | readout_active_i;
			default:               busy = exposure_active_i | readout_active_i;
		endcase

		// level modes let the pulse width set exposure; edges pulse once
		nxt_st.line_out = 1'b0;
		if (is_lvl && lsrc == trig_pkg::LSRC_PIN) begin
			if (st_ff.lvl) begin
				nxt_st.lvl = l_valid;                     // [RULE_07]
			end else begin
				nxt_st.lvl = l_ev & ~busy;                // [RULE_05] [RULE_06]
			end
			nxt_st.line_out = nxt_st.lvl;
			nxt_st.pend     = 1'b0;
		end else begin
			nxt_st.lvl = 1'b0;
			if (l_ev && !busy) begin
				nxt_st.line_out = 1'b1;                   // [RULE_07]
			end else if (l_ev && win == trig_pkg::WIN_PRIOR) begin
				nxt_st.pend = 1'b1;                       // [RULE_11]
			end else if (st_ff.pend && !busy) begin
				nxt_st.line_out = 1'b1;                   // [RULE_11]
				nxt_st.pend     = 1'b0;
			end
		end

		// frame channel; internal source is taken as is
		f_cur = st_ff.stab[trig_pkg::PIN_FRAME];
		f_old = st_ff.prev[trig_pkg::PIN_FRAME];
		if (st_ff.ctrl[trig_pkg::F_FSRC]) begin
			f_ev = int_frame_i;                           // [RULE_01]
		end else begin
			f_ev = qual_event(qsel, f_cur, f_old);        // [RULE_03] [RULE_04]
		end
		// frame pin shares the qualify mode but has no inverter
		f_acc = f_ev & (st_ff.ctrl[trig_pkg::F_FOVL] | ~frame_active_i); // [RULE_08]

		// delay timebase: microsecond tick or every line pulse seen
		if (st_ff.usdiv == 8'(trig_pkg::US_CYCLES - 1)) begin
			nxt_st.usdiv = 8'h00;
		end else begin
			nxt_st.usdiv = st_ff.usdiv + 8'h01;
		end
		// the line tick uses every qualified line event, taken or refused
		tick = st_ff.ctrl[trig_pkg::F_DSEL] ? l_ev        // [RULE_15]
			: (st_ff.usdiv == 8'(trig_pkg::US_CYCLES - 1)); // [RULE_14]
		nxt_st.tcount = st_ff.tcount + {31'h0000_0000, tick};

		// head slot fires once its due stamp is reached
		// signed difference keeps the compare right across stamp wrap,
		// as long as no delay exceeds half the counter range
		diff = st_ff.tcount - mem_rdata;
		pop  = (st_ff.cnt != 8'h00) && (st_ff.stale == 2'h0) && !diff[31]; // [RULE_12]
		push = f_acc && (st_ff.cnt != trig_pkg::SLOT_FULL);   // [RULE_13]
		nxt_st.fire = pop;
		if (f_acc && !push) begin
			nxt_st.drops = st_ff.drops + 8'h01;               // [RULE_13]
		end
		// the stamp written with the push is absolute, not a countdown
		mem_we    = push;
		mem_waddr = st_ff.wptr;
		mem_wdata = st_ff.tcount + st_ff.delay;               // [RULE_12]
		if (push) begin
			nxt_st.wptr = st_ff.wptr + 7'h01;
		end
		if (pop) begin
			nxt_st.rptr = st_ff.rptr + 7'h01;
		end
		// count is one bit wider than the pointers, telling full from empty
		nxt_st.cnt = st_ff.cnt + {7'h00, push} - {7'h00, pop};
		// memory read is registered, so the head needs two settling cycles
		if (pop || (push && st_ff.cnt == 8'h00)) begin
			nxt_st.stale = 2'h2;
		end else if (st_ff.stale != 2'h0) begin
			nxt_st.stale = st_ff.stale - 2'h1;
		end

		// pulses reaching the line stage counted over a fixed gate
		// the rate lags by up to one gate; a shorter gate reacts faster
		// but reads with coarser resolution
		if (st_ff.gate == GATE_CYC - 1) begin
			nxt_st.gate   = 32'h0000_0000;
			nxt_st.rate   = st_ff.pcount + {31'h0000_0000, l_ev}; // [RULE_16]
			nxt_st.pcount = 32'h0000_0000;
		end else begin
			nxt_st.gate   = st_ff.gate + 32'h0000_0001;
			nxt_st.pcount = st_ff.pcount + {31'h0000_0000, l_ev}; // [RULE_16]
		end

		// quadrature step; exactly one phase must change
		// a bounce of one phase gives a step each way: it cancels in
		// position mode but yields two pulses in motion mode
		a_old = st_ff.prev[trig_pkg::PIN_A];
		b_new = st_ff.stab[trig_pkg::PIN_B];
		step  = ^(st_ff.stab[3:2] ^ st_ff.prev[3:2]);
		// a_old ^ b_new is set when phase b leads, i.e. clockwise
		fwd   = (a_old ^ b_new) ^ st_ff.ctrl[trig_pkg::F_FSENSE]; // [RULE_21]
		nxt_st.enc_out = 1'b0;
		if (step) begin
			if (!st_ff.ctrl[trig_pkg::F_GMODE]) begin
				nxt_st.enc_out = 1'b1;                        // [RULE_20]
			end else if (!fwd) begin
				if (st_ff.rev != trig_pkg::REV_LIMIT) begin
					nxt_st.rev = st_ff.rev + 9'h001;          // [RULE_17] [RULE_19]
				end
			end else if (st_ff.rev != 9'h000) begin
				nxt_st.rev = st_ff.rev - 9'h001;              // [RULE_18]
			end else begin
				nxt_st.enc_out = 1'b1;                        // [RULE_18]
			end
		end
		if (!st_ff.ctrl[trig_pkg::F_GMODE]) begin
			nxt_st.rev = 9'h000;                              // [RULE_20]
		end

		// apb slave: answer one cycle into the access phase
		// exactly one wait state is always added; the answer stands one cycle only
		acc = psel_i & penable_i & ~st_ff.pready;
		case (paddr_i)
			trig_pkg::OFS_CTRL:   rd = {19'h00000, st_ff.ctrl};
			trig_pkg::OFS_DELAY:  rd = st_ff.delay;
			trig_pkg::OFS_RATE:   rd = st_ff.rate;
			trig_pkg::OFS_STATUS: begin
				rd[trig_pkg::F_PEND +: 8] = st_ff.cnt;
				rd[trig_pkg::F_DROP +: 8] = st_ff.drops;
				rd[trig_pkg::F_REV +: 9]  = st_ff.rev;
			end
			default:              hit = 1'b0;
		endcase
		nxt_st.pready  = acc;
		nxt_st.pslverr = acc & ~hit;
		nxt_st.prdata  = (acc && !pwrite_i) ? rd : 32'h0000_0000;
		// write commits at the edge that samples pready high
		if (psel_i && penable_i && st_ff.pready && pwrite_i) begin
			if (paddr_i == trig_pkg::OFS_CTRL) begin
				nxt_st.ctrl = pwdata_i[trig_pkg::CTRL_W-1:0];
			end else if (paddr_i == trig_pkg::OFS_DELAY) begin
				nxt_st.delay = pwdata_i;
			end
		end
	end

	// single state register
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			// settings take their reset values; everything else clears
			st_ff       <= '0;
			st_ff.ctrl  <= trig_pkg::CTRL_RST;
			st_ff.delay <= trig_pkg::DELAY_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs come straight from the state register
	assign pready_o              = st_ff.pready;
	assign prdata_o              = st_ff.prdata;
	assign pslverr_o             = st_ff.pslverr;
	assign line_trig_o           = st_ff.line_out;
	assign delayed_trigger_out_o = st_ff.fire;
	assign enc_trig_o            = st_ff.enc_out;
endmodule

// ---- tb/trig_unit_monitor.sv ----
// port checker for the trigger qualify and delay unit
`timescale 1ns/1ps
module trig_unit_monitor (
	input wire logic        clk_sys_i,             // system clock
	input wire logic        sys_rst_i,             // async reset
	input wire logic        psel_i,                // apb select
	input wire logic        penable_i,             // apb access
	input wire logic [7:0]  paddr_i,               // apb address
	input wire logic        pready_o,              // apb ready
	input wire logic [31:0] prdata_o,              // apb read data
	input wire logic        pslverr_o,             // apb error
	input wire logic        enc_a_i,               // phase a pin
	input wire logic        enc_b_i,               // phase b pin
	input wire logic        line_trig_o,           // line trigger
	input wire logic        delayed_trigger_out_o, // delayed frame
	input wire logic        enc_trig_o             // encoder step
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic [1:0] ab_ff;   // last sampled phases
	logic [3:0] idle_ff; // cycles since a phase change, capped
	// capped so a long idle stretch never wraps into a false cause
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ab_ff <= 2'h0;
			idle_ff <= 4'hF;
		end else begin
			ab_ff <= {enc_a_i, enc_b_i};
			if ({enc_a_i, enc_b_i} != ab_ff)
				idle_ff <= 4'h0;
			else if (idle_ff != 4'hF)
				idle_ff <= idle_ff + 4'h1;
		end
	end
	sequence s_access;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence s_answer;
		pready_o ##1 !pready_o;
	endsequence
	property p_answer;
		s_access |=> s_answer;
	endproperty
	apb_answer_a: assert property (p_answer)
		else $error("apb answer late or too long");
	ready_cause_a: assert property (
		pready_o |-> $past(psel_i && penable_i))
		else $error("ready without request");
	rdata_idle_a: assert property (
		!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside answer");
	err_decode_a: assert property (
		pready_o |-> pslverr_o == !(paddr_i inside
		{8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("error flag wrong for address");
	err_data_a: assert property (
		pready_o && pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read returned data");
	delay_spacing_a: assert property (
		delayed_trigger_out_o |=> !delayed_trigger_out_o [*2])
		else $error("delayed triggers too close");
	enc_cause_a: assert property (
		enc_trig_o |-> idle_ff <= 4'hA)
		else $error("encoder step without phase change");
	reset_quiet_a: assert property (
		$fell(sys_rst_i) |-> !line_trig_o && !enc_trig_o
		&& !delayed_trigger_out_o)
		else $error("output active at reset release");
endmodule

// ---- tb/trig_source.sv ----
// external line trigger and quadrature encoder source model
`timescale 1ns/1ps
module trig_source (
	input  wire logic clk_sys_i,   // system clock
	output logic      line_pin_o,  // line trigger pin
	output logic      frame_pin_o, // frame trigger pin
	output logic      enc_a_o,     // encoder phase a
	output logic      enc_b_o      // encoder phase b
);
	int pos; // quadrature position, low two bits used
	initial begin
		line_pin_o = 1'b0;
		frame_pin_o = 1'b0;
		enc_a_o = 1'b0;
		enc_b_o = 1'b0;
		pos = 0;
	end
	// level held long enough for the pin synchroniser to see it
	task automatic line_set(input logic v, input int gap);
		@(posedge clk_sys_i);
		line_pin_o <= v;
		repeat (gap) @(posedge clk_sys_i);
	endtask
	// frame pin level held long enough for the synchroniser
	task automatic frame_set(input logic v, input int gap);
		@(posedge clk_sys_i);
		frame_pin_o <= v;
		repeat (gap) @(posedge clk_sys_i);
	endtask
	// one gray step; b_lead set means phase b changes first
	task automatic step(input logic b_lead, input int gap);
		@(posedge clk_sys_i);
		pos = b_lead ? pos + 1 : pos - 1;
		enc_a_o <= pos[1];
		enc_b_o <= pos[1] ^ pos[0];
		repeat (gap) @(posedge clk_sys_i);
	endtask
endmodule

// ---- tb/test_trig_unit.sv ----
// self-checking testbench for the trigger unit
`timescale 1ns/1ps
module test_trig_unit;
	localparam int GATE = 100; // short rate gate keeps the run brief
	localparam int QV [4] = '{0, 1, 2, 512};
	localparam int QE [4] = '{2, 1, 3, 1};
	localparam int WV [4] = '{1025, 1033, 1033, 1041};
	localparam int WE [4] = '{0, 0, 1, 1};
	localparam int WX [4] = '{0, 1, 0, 1};
	localparam int PS [3] = '{0, 1, 0};
	localparam int PR [3] = '{3, 3, 260};
	localparam int PC [3] = '{3, 3, 256};
	logic        clk_sys_i, sys_rst_i, psel, pen, pwr, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        line_pin, frame_pin, enc_a, enc_b, int_line, int_frame;
	logic        expo, rdout, fact, line_trig, dly_trig, enc_trig;
	int          n_line = 0, n_dly = 0, n_enc = 0;
	int          error_cnt = 0, compares = 0, seed = 40920;
	trig_unit #(.GATE_CYC(GATE)) i_trig_unit (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
		.line_pin_i(line_pin), .frame_pin_i(frame_pin), .enc_a_i(enc_a),
		.enc_b_i(enc_b), .int_line_i(int_line), .int_frame_i(int_frame),
		.exposure_active_i(expo), .readout_active_i(rdout),
		.frame_active_i(fact), .line_trig_o(line_trig),
		.delayed_trigger_out_o(dly_trig), .enc_trig_o(enc_trig));
	trig_source src (.clk_sys_i(clk_sys_i), .line_pin_o(line_pin),
		.frame_pin_o(frame_pin), .enc_a_o(enc_a), .enc_b_o(enc_b));
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// model tallies of output pulses, compared as differences
	always @(posedge clk_sys_i) begin
		n_line <= n_line + (line_trig === 1'b1);
		n_dly <= n_dly + (dly_trig === 1'b1);
		n_enc <= n_enc + (enc_trig === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic summarize;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	// apb transfer; holds the request until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("apb ready", 32'h1, {31'h0, pready});
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic pulse(input bit fr);
		if (fr)
			int_frame <= 1'b1;
		else
			int_line <= 1'b1;
		@(posedge clk_sys_i);
		int_frame <= 1'b0;
		int_line <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	initial begin
		int b;
		logic [31:0] v;
		{psel, pen, pwr, paddr, pwdata} = '0;
		{int_line, int_frame, expo, rdout, fact} = '0;
		sys_rst_i = 1'b1;
		cyc(10);
		sys_rst_i <= 1'b0;
		cyc(1);
		apb(0, 8'h00, 0);
		chk("ctrl reset", 32'h0, rd);
		apb(0, 8'h10, 0);
		chk("unmapped", 32'h0, rd);
		v = $random(seed);
		apb(1, 8'h04, v);
		apb(0, 8'h04, 0);
		chk("delay", v, rd);
		apb(1, 8'h00, v);
		apb(0, 8'h00, 0);
		chk("ctrl", v & 32'h1FFF, rd);
		// three toggles from low: two rises and one fall
		for (int i = 0; i < 4; i++) begin
			src.line_set(1'b0, 12);
			apb(1, 8'h00, QV[i]);
			cyc(12);
			b = n_line;
			for (int k = 0; k < 3; k++)
				src.line_set(~line_pin, 8 + ({$random(seed)} % 8));
			cyc(8);
			chk("edges", QE[i], n_line - b);
		end
		for (int q = 3; q < 5; q++) begin
			src.line_set(q == 4, 12);
			apb(1, 8'h00, q);
			src.line_set(q == 3, 20);
			chk("level on", 1, line_trig);
			src.line_set(q == 4, 20);
			chk("level off", 0, line_trig);
		end
		// internal pulse against busy flags in each accept window
		for (int i = 0; i < 4; i++) begin
			apb(1, 8'h00, WV[i]);
			expo <= WE[i];
			rdout <= !WE[i];
			cyc(1);
			b = n_line;
			pulse(0);
			cyc(5);
			expo <= 1'b0;
			rdout <= 1'b0;
			cyc(10);
			chk("window", WX[i], n_line - b);
		end
		apb(1, 8'h04, 0);
		apb(1, 8'h00, 32'h1000);
		fact <= 1'b1;
		b = n_dly;
		pulse(1);
		cyc(20);
		chk("overlap drop", b, n_dly);
		fact <= 1'b0;
		pulse(1);
		cyc(20);
		chk("overlap pass", b + 1, n_dly);
		apb(1, 8'h04, 3);
		b = n_dly;
		pulse(1);
		cyc(380);
		chk("us early", b, n_dly);
		cyc(440);
		chk("us due", b + 1, n_dly);
		// rejected line pulses still advance the line-tick delay
		apb(1, 8'h04, 2);
		apb(1, 8'h00, 32'h1441);
		expo <= 1'b1;
		b = n_dly;
		pulse(1);
		cyc(30);
		chk("line early", b, n_dly);
		pulse(0);
		pulse(0);
		cyc(30);
		chk("line due", b + 1, n_dly);
		expo <= 1'b0;
		for (int i = 0; i < 30; i++) begin
			pulse(0);
			if (i == 29)
				apb(0, 8'h08, 0);
			cyc(i == 29 ? 4 : 8);
		end
		chk("rate", 10, rd);
		apb(1, 8'h00, 0);
		b = n_enc;
		repeat (4) src.step(1, 10);
		repeat (4) src.step(0, 10);
		cyc(10);
		chk("motion", b + 8, n_enc);
		for (int i = 0; i < 3; i++) begin
			apb(1, 8'h00, 32'h80 | (PS[i] << 8));
			b = n_enc;
			repeat (PR[i]) src.step(PS[i], 10);
			apb(0, 8'h0C, 0);
			chk("reverse", PC[i], rd[24:16]);
			repeat (PR[i] + 2) src.step(!PS[i], 10);
			cyc(10);
			chk("position", PR[i] + 2 - PC[i], n_enc - b);
		end
		// frame pin through any-edge qualify, no delay: two triggers
		apb(1, 8'h04, 0);
		apb(1, 8'h00, 32'h2);
		b = n_dly;
		src.frame_set(1'b1, 12);
		src.frame_set(1'b0, 12);
		cyc(8);
		chk("frame pin", b + 2, n_dly);
		// fill every slot with a long delay, then two more are lost
		apb(1, 8'h04, 32'h100);
		apb(1, 8'h00, 32'h1441);
		apb(0, 8'h0C, 0);
		v = rd;
		repeat (130) pulse(1);
		cyc(5);
		apb(0, 8'h0C, 0);
		chk("slots", {v[15:8] + 8'h02, 8'h80}, rd[15:0]);
		summarize();
	end
	// hang guard, far beyond the expected run
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
endmodule
bind trig_unit trig_unit_monitor i_mon (.clk_sys_i, .sys_rst_i,
	.psel_i, .penable_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o,
	.enc_a_i, .enc_b_i, .line_trig_o, .delayed_trigger_out_o,
	.enc_trig_o);
